/* hw/cfg_slot_store.sv */
// configuration slot store: six words with a valid flag each
// assumes the parent guarantees the slot index is legal on a write
`timescale 1ns/1ps
module cfg_slot_store
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic wrEn,
	input wire logic [2:0] wrSlot,
	input wire logic [31:0] wrData,
	input wire logic purge,
	input wire logic [2:0] rdSlot,
	output logic [31:0] rdData,
	output logic rdValid
);

	// ****************************************
	// storage
	// ****************************************
	logic [31:0] mem [status_cfg_pkg::SLOT_N]; // slot contents, not reset
	logic [status_cfg_pkg::SLOT_N-1:0] valid; // slot holds a file
	logic [status_cfg_pkg::SLOT_N-1:0] next_valid;

	// valid flags: purge wins, a save creates the file
	always_comb
	begin
		next_valid = valid;
		for (int i = 0; i < status_cfg_pkg::SLOT_N; i++)
		begin
			if (wrEn && wrSlot == 3'(i))
				next_valid[i] = 1'b1;
		end
		if (purge)
			next_valid = '0;
	end

	// reset stands in for shipping, every slot empty
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			valid <= '0;
		else
			valid <= next_valid;
	end

	// data words, one per slot; overwrite raises nothing
	genvar g;
	generate
		for (g = 0; g < status_cfg_pkg::SLOT_N; g++)
		begin : gSlot
			always_ff @(posedge core_clk)
			begin
				if (wrEn && wrSlot == 3'(g))
					mem[g] <= wrData;
			end
		end
	endgenerate

	// registered read port
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			rdData <= '0;
			rdValid <= 1'b0;
		end
		else if (rdSlot <= status_cfg_pkg::SLOT_LAST)
		begin
			rdData <= mem[rdSlot];
			rdValid <= valid[rdSlot];
		end
		else
		begin
			rdData <= '0;
			rdValid <= 1'b0;
		end
	end

endmodule // cfg_slot_store

/* hw/status_byte_and_config_store.sv */
// status summary byte, its enable mask, power-on clear option, slots, bus trigger
// assumes a command decoder issues one-cycle command strobes on core_clk
`timescale 1ns/1ps
module status_byte_and_config_store
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic powerOn,
	input wire logic cmdValid,
	input wire logic [3:0] cmdCode,
	input wire logic [7:0] cmdArg,
	input wire logic [31:0] activeCfgIn,
	input wire logic operSummary,
	input wire logic stdEvSummary,
	input wire logic quesSummary,
	input wire logic alarmSummary,
	input wire logic outBufReady,
	input wire logic errQueueNonEmpty,
	input wire logic busTrigMode,
	input wire logic armReq,
	input wire logic passDone,
	output logic [7:0] statusSummary,
	output logic [7:0] summaryEnable,
	output logic onClearOption,
	output logic clearEnables,
	output logic clearEvents,
	output logic factoryReset,
	output logic [31:0] activeCfg,
	output logic cfgLoad,
	output logic recallError,
	output logic startPass,
	output logic armed
);

	// ****************************************
	// command decode
	// ****************************************
	status_cfg_pkg::cmd_t cmd; // decoded command, NONE when idle
	assign cmd = cmdValid ? status_cfg_pkg::cmd_t'(cmdCode) : status_cfg_pkg::CMD_NONE;

	// ****************************************
	// option and enable register
	// ****************************************
	logic next_onClearOption;
	logic [7:0] next_summaryEnable;
	logic next_clearEnables;
	logic next_clearEvents;
	logic next_factoryReset;

	// option survives power cycles; only a command or reset changes it
	always_comb
	begin
		next_onClearOption = onClearOption;
		next_summaryEnable = summaryEnable;
		next_clearEnables = 1'b0;
		next_clearEvents = 1'b0;
		next_factoryReset = 1'b0;
		if (cmd == status_cfg_pkg::CMD_SET_ONCLR)
			next_onClearOption = cmdArg[0];
		if (cmd == status_cfg_pkg::CMD_SET_ENABLE)
			next_summaryEnable = cmdArg & status_cfg_pkg::ENABLE_WMASK;
		if (cmd == status_cfg_pkg::CMD_CLEAR)
			next_clearEvents = 1'b1;
		if (cmd == status_cfg_pkg::CMD_FACTORY)
			next_factoryReset = 1'b1;
		// power-on clear of every enable mask, events left alone
		if (powerOn && onClearOption)
		begin
			next_summaryEnable = status_cfg_pkg::ENABLE_RST;
			next_clearEnables = 1'b1;
		end
	end

	// enable reset to zero; option defaults to set
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			onClearOption <= status_cfg_pkg::ONCLR_RST;
			summaryEnable <= status_cfg_pkg::ENABLE_RST;
			clearEnables <= 1'b0;
			clearEvents <= 1'b0;
			factoryReset <= 1'b0;
		end
		else
		begin
			onClearOption <= next_onClearOption;
			summaryEnable <= next_summaryEnable;
			clearEnables <= next_clearEnables;
			clearEvents <= next_clearEvents;
			factoryReset <= next_factoryReset;
		end
	end

	// ****************************************
	// status summary byte
	// ****************************************
	logic [7:0] rawSummary; // summary bits without the master
	logic [7:0] next_statusSummary;

	// a plain condition register: reads never clear it
	always_comb
	begin
		rawSummary = '0;
		rawSummary[status_cfg_pkg::BIT_OPER] = operSummary;
		rawSummary[status_cfg_pkg::BIT_STDEV] = stdEvSummary;
		rawSummary[status_cfg_pkg::BIT_MAV] = outBufReady;
		rawSummary[status_cfg_pkg::BIT_QUES] = quesSummary;
		rawSummary[status_cfg_pkg::BIT_ERRQ] = errQueueNonEmpty;
		rawSummary[status_cfg_pkg::BIT_ALARM] = alarmSummary;
		next_statusSummary = rawSummary;
		// master uses current enable; bit 6 masked so it cannot latch itself
		next_statusSummary[status_cfg_pkg::BIT_MASTER] =
			|(rawSummary & summaryEnable & status_cfg_pkg::MASTER_MASK);
	end

	// binary byte equals the weighted sum a query reports
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			statusSummary <= '0;
		else
			statusSummary <= next_statusSummary;
	end

	// ****************************************
	// configuration slots
	// ****************************************
	logic slotWr; // save strobe to the store
	logic slotLegal; // argument names slot 0 to 5
	logic [31:0] slotData;
	logic slotValid;
	logic recallPend; // recall waits one cycle for read data
	logic next_recallPend;
	logic [31:0] next_activeCfg;
	logic next_cfgLoad;
	logic next_recallError;

	assign slotLegal = cmdArg[7:3] == 5'h00 && cmdArg[2:0] <= status_cfg_pkg::SLOT_LAST;
	assign slotWr = cmd == status_cfg_pkg::CMD_SAVE && slotLegal;

	// the saved word carries scan list and channel settings as one image
	cfg_slot_store uStore
	(
		.core_clk(core_clk),
		.rst_n(rst_n),
		.wrEn(slotWr),
		.wrSlot(cmdArg[2:0]),
		.wrData(activeCfgIn),
		.purge(cmd == status_cfg_pkg::CMD_PURGE),
		.rdSlot(cmdArg[2:0]),
		.rdData(slotData),
		.rdValid(slotValid)
	);

	// recall loads the slot; an empty or bad slot flags an error
	always_comb
	begin
		next_recallPend = cmd == status_cfg_pkg::CMD_RECALL && slotLegal;
		next_activeCfg = activeCfg;
		next_cfgLoad = 1'b0;
		next_recallError = 1'b0;
		if (cmd == status_cfg_pkg::CMD_RECALL && !slotLegal)
			next_recallError = 1'b1;
		if (recallPend)
		begin
			if (slotValid)
			begin
				next_activeCfg = slotData;
				next_cfgLoad = 1'b1;
			end
			else
				next_recallError = 1'b1;
		end
		// factory image only; slots themselves are untouched
		if (cmd == status_cfg_pkg::CMD_FACTORY)
		begin
			next_activeCfg = status_cfg_pkg::CFG_FACTORY;
			next_cfgLoad = 1'b1;
		end
	end

	// slot command registers
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			recallPend <= 1'b0;
			activeCfg <= status_cfg_pkg::CFG_FACTORY;
			cfgLoad <= 1'b0;
			recallError <= 1'b0;
		end
		else
		begin
			recallPend <= next_recallPend;
			activeCfg <= next_activeCfg;
			cfgLoad <= next_cfgLoad;
			recallError <= next_recallError;
		end
	end

	// ****************************************
	// bus trigger
	// ****************************************
	status_cfg_pkg::trig_state_t trigState;
	status_cfg_pkg::trig_state_t next_trigState;
	logic next_startPass;

	// triggers outside armed bus mode are ignored, as with a combined read
	always_comb
	begin
		next_trigState = trigState;
		next_startPass = 1'b0;
		unique case (trigState)
			status_cfg_pkg::TRIG_IDLE:
			begin
				if (armReq)
					next_trigState = status_cfg_pkg::TRIG_ARMED;
			end
			status_cfg_pkg::TRIG_ARMED:
			begin
				if (cmd == status_cfg_pkg::CMD_BUS_TRIG && busTrigMode)
				begin
					next_startPass = 1'b1;
					next_trigState = status_cfg_pkg::TRIG_SCAN;
				end
			end
			status_cfg_pkg::TRIG_SCAN:
			begin
				if (passDone)
					next_trigState = status_cfg_pkg::TRIG_ARMED;
			end
			default:
				next_trigState = status_cfg_pkg::TRIG_IDLE;
		endcase
		if (cmd == status_cfg_pkg::CMD_FACTORY)
			next_trigState = status_cfg_pkg::TRIG_IDLE;
	end

	// trigger state registers
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			trigState <= status_cfg_pkg::TRIG_IDLE;
			startPass <= 1'b0;
			armed <= 1'b0;
		end
		else
		begin
			trigState <= next_trigState;
			startPass <= next_startPass;
			armed <= next_trigState == status_cfg_pkg::TRIG_ARMED;
		end
	end

endmodule // status_byte_and_config_store

/* hw/status_cfg_pkg.sv */
// status summary and configuration store: shared constants and types
// assumes one 250 MHz core clock and a command decoder in front of the block
// Operation
// - power-on clear option zeroes enables, default set
// - power-on clear covers all five register sets
// - option query returns 1 cleared, 0 kept
// - factory reset keeps I/O settings untouched
// - six slots; save overwrites silently, creates file
// - recall replaces active configuration with slot
// - slot holds scan and channel settings
// - all slots empty as delivered
// - factory reset keeps slots; purge erases all
// - summary enable eight bits, reset zero, bit0 zero
// - bit 7 is operation summary
// - bit 6 is master summary
// - bit 5 is standard event summary
// - bit 4 means response data waiting
// - bit 3 is questionable summary
// - bit 2 means error queue not empty
// - bit 1 is alarm summary
// - reading summary byte clears nothing
// - queries return weighted sum of set bits
// - bus trigger while armed starts one pass
// - clear-status zeroes events, keeps enables
package status_cfg_pkg;

	// ****************************************
	// widths
	// ****************************************
	localparam int CFG_W = 32; // width of one saved configuration word
	localparam int SLOT_N = 6; // number of configuration slots
	localparam int SLOT_W = 3; // width of a slot index
	localparam int BYTE_W = 8; // width of summary byte and masks

	// ****************************************
	// summary bit positions
	// ****************************************
	localparam int BIT_ALARM = 1;
	localparam int BIT_ERRQ = 2;
	localparam int BIT_QUES = 3;
	localparam int BIT_MAV = 4;
	localparam int BIT_STDEV = 5;
	localparam int BIT_MASTER = 6;
	localparam int BIT_OPER = 7;

	// ****************************************
	// reset values and masks
	// ****************************************
	localparam logic [7:0] ENABLE_RST = 8'h00; // enable register reset value
	localparam logic [7:0] ENABLE_WMASK = 8'hfe; // bit 0 always zero
	localparam logic [7:0] MASTER_MASK = 8'hbf; // every bit but the master
	localparam logic ONCLR_RST = 1'b1; // power-on clear option default
	localparam logic [31:0] CFG_FACTORY = 32'h0000_0000; // factory configuration
	localparam logic [2:0] SLOT_LAST = 3'h5; // highest legal slot index

	// command codes from the decoder
	typedef enum logic [3:0] {
		CMD_NONE = 4'b0000,
		CMD_SET_ENABLE = 4'b0001,
		CMD_SET_ONCLR = 4'b0010,
		CMD_FACTORY = 4'b0011,
		CMD_SAVE = 4'b0100,
		CMD_RECALL = 4'b0101,
		CMD_PURGE = 4'b0110,
		CMD_CLEAR = 4'b0111,
		CMD_BUS_TRIG = 4'b1000
	} cmd_t;

	// trigger system states
	typedef enum logic [1:0] {
		TRIG_IDLE = 2'b00,
		TRIG_ARMED = 2'b01,
		TRIG_SCAN = 2'b10
	} trig_state_t;

endpackage

/* verif/scan_engine_model.sv */
// scan engine stand-in: answers each pass start with a done pulse, none when passLen is zero
// assumes startPass is a one-cycle pulse on core_clk
`timescale 1ns/1ps
module scan_engine_model
(
	input wire logic core_clk,
	input wire logic startPass,
	input wire logic [3:0] passLen,
	output logic passDone = 1'b0
);
	// cycles left in the running pass
	logic [3:0] left = 4'h0;
	// ****
	// pass timing
	// ****
	// a pass runs passLen cycles, so short and slow answers both occur
	always @(posedge core_clk)
	begin
		passDone <= 1'b0;
		if (startPass)
			left <= passLen;
		else if (left != 4'h0)
		begin
			left <= left - 4'h1;
			passDone <= (left == 4'h1);
		end
	end
endmodule // scan_engine_model

/* verif/status_byte_and_config_store_tb.sv */
// self-checking bench for the summary byte and slot store
// assumes the scan stand-in answers each pass start
`timescale 1ns/1ps
module status_byte_and_config_store_tb;
	// ****
	// stimulus and wiring
	// ****
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic powerOn = 1'b0;
	logic cmdValid = 1'b0;
	logic [3:0] cmdCode = 4'h0;
	logic [7:0] cmdArg = 8'h00;
	logic [31:0] activeCfgIn = 32'h0;
	logic [5:0] src = 6'h00; // oper stdev mav ques errq alarm
	logic busTrigMode = 1'b0;
	logic armReq = 1'b0;
	logic [3:0] passLen = 4'h4;
	logic passDone;
	logic [7:0] statusSummary;
	logic [7:0] summaryEnable;
	logic [31:0] activeCfg;
	logic onClearOption, clearEnables, clearEvents, factoryReset;
	logic cfgLoad, recallError, startPass, armed;
	int errors = 0;
	int checks = 0;
	always #2 core_clk = ~core_clk;
	status_byte_and_config_store status_byte_and_config_store_i (.core_clk, .rst_n,
		.powerOn, .cmdValid, .cmdCode, .cmdArg, .activeCfgIn, .operSummary(src[5]),
		.stdEvSummary(src[4]), .outBufReady(src[3]), .quesSummary(src[2]),
		.errQueueNonEmpty(src[1]), .alarmSummary(src[0]), .busTrigMode, .armReq,
		.passDone, .statusSummary, .summaryEnable, .onClearOption, .clearEnables,
		.clearEvents, .factoryReset, .activeCfg, .cfgLoad, .recallError, .startPass, .armed);
	scan_engine_model scan_engine_model_i (.core_clk, .startPass, .passLen, .passDone);
	// ****
	// shared tasks
	// ****
	task automatic final_report;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one command; on return its one-cycle answers are visible
	task automatic send(input logic [3:0] c, input logic [7:0] a);
		@(negedge core_clk);
		cmdValid = 1'b1;
		cmdCode = c;
		cmdArg = a;
		@(negedge core_clk);
		cmdValid = 1'b0;
	endtask
	task automatic pwr;
		@(negedge core_clk);
		powerOn = 1'b1;
		@(negedge core_clk);
		powerOn = 1'b0;
	endtask
	// bounded wait for the trigger system to rearm
	task automatic wait_armed;
		int n;
		for (n = 0; n < 20 && armed !== 1'b1; n++)
			@(negedge core_clk);
		if (armed !== 1'b1)
		begin
			errors++;
			$display("MISMATCH %0t never rearmed", $time);
			final_report;
		end
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_reset;
		cmp(summaryEnable, 8'h00);
		cmp(onClearOption, 1'b1);
		cmp(statusSummary, 8'h00);
		send(4'h5, 8'h00);
		@(negedge core_clk);
		cmp(recallError, 1'b1);
	endtask
	task automatic t_summary;
		send(4'h1, 8'h91);
		cmp(summaryEnable, 8'h90);
		send(4'h1, 8'hff);
		cmp(summaryEnable, 8'hfe);
		for (int i = 0; i < 6; i++)
		begin
			src = 6'h01 << i;
			@(negedge core_clk);
			cmp(statusSummary, {src[5], 1'b1, src[4:0], 1'b0});
			@(negedge core_clk);
			cmp(statusSummary, {src[5], 1'b1, src[4:0], 1'b0});
		end
		// masked source must not reach the master bit
		send(4'h1, 8'h00);
		@(negedge core_clk);
		cmp(statusSummary, 8'h80);
		src = 6'h00;
	endtask
	task automatic t_option;
		send(4'h1, 8'h90);
		send(4'h2, 8'h00);
		cmp(onClearOption, 1'b0);
		pwr;
		cmp({clearEnables, summaryEnable}, 9'h090);
		send(4'h2, 8'h01);
		cmp(onClearOption, 1'b1);
		pwr;
		cmp({clearEnables, summaryEnable}, 9'h100);
		send(4'h1, 8'h24);
		send(4'h7, 8'h00);
		cmp({clearEvents, summaryEnable}, 9'h124);
	endtask
	task automatic t_slots;
		activeCfgIn = 32'h1234_5678;
		send(4'h4, 8'h05);
		activeCfgIn = 32'hcafe_0001;
		send(4'h4, 8'h05);
		activeCfgIn = 32'hdead_beef;
		send(4'h4, 8'h06);
		send(4'h5, 8'h06);
		cmp(recallError, 1'b1);
		send(4'h5, 8'h05);
		@(negedge core_clk);
		cmp({cfgLoad, activeCfg}, 33'h1_cafe_0001);
		send(4'h3, 8'h00);
		cmp({factoryReset, activeCfg, summaryEnable}, 41'h100_0000_0024);
		send(4'h5, 8'h05);
		@(negedge core_clk);
		cmp(activeCfg, 32'hcafe_0001);
		send(4'h6, 8'h00);
		send(4'h5, 8'h05);
		@(negedge core_clk);
		cmp(recallError, 1'b1);
	endtask
	task automatic t_trigger;
		send(4'h8, 8'h00);
		cmp(startPass, 1'b0);
		busTrigMode = 1'b1;
		@(negedge core_clk);
		armReq = 1'b1;
		@(negedge core_clk);
		armReq = 1'b0;
		cmp(armed, 1'b1);
		send(4'h8, 8'h00);
		cmp(startPass, 1'b1);
		send(4'h8, 8'h00);
		cmp(startPass, 1'b0);
		wait_armed;
		passLen = 4'h1;
		send(4'h8, 8'h00);
		cmp(startPass, 1'b1);
		wait_armed;
		busTrigMode = 1'b0;
		send(4'h8, 8'h00);
		cmp(startPass, 1'b0);
	endtask
	initial
	begin
		repeat (8) @(negedge core_clk);
		rst_n = 1'b1;
		t_reset;
		t_summary;
		t_option;
		t_slots;
		t_trigger;
		final_report;
	end
endmodule // status_byte_and_config_store_tb

/* verif/status_cfg_monitor.sv */
// checker for the summary byte, option and trigger ports
// assumes it is bound onto the top module, one clock domain
`timescale 1ns/1ps
module status_cfg_monitor
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic powerOn,
	input wire logic cmdValid,
	input wire logic [3:0] cmdCode,
	input wire logic [7:0] cmdArg,
	input wire logic operSummary,
	input wire logic stdEvSummary,
	input wire logic quesSummary,
	input wire logic alarmSummary,
	input wire logic outBufReady,
	input wire logic errQueueNonEmpty,
	input wire logic busTrigMode,
	input wire logic [7:0] statusSummary,
	input wire logic [7:0] summaryEnable,
	input wire logic onClearOption,
	input wire logic clearEnables,
	input wire logic clearEvents,
	input wire logic recallError,
	input wire logic startPass,
	input wire logic armed
);
	// ****
	// helpers
	// ****
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// power-up with the option set wins over a same-cycle enable write
	logic take;
	assign take = cmdValid && !powerOn;
	// gated summaries and plain levels
	logic [3:0] sums;
	assign sums = {operSummary, stdEvSummary, quesSummary, alarmSummary};
	logic [1:0] lvl;
	assign lvl = {outBufReady, errQueueNonEmpty};
	// ****
	// assertions
	// ****
	chk_mask_bit0: assert property (
		summaryEnable[0] == 1'b0) else $error("enable bit 0 set");
	chk_enable_write: assert property (
		take && cmdCode == 4'h1 |=> summaryEnable == ($past(cmdArg) & 8'hfe))
		else $error("enable write wrong");
	chk_enabled_sums: assert property (
		1 |=> {statusSummary[7], statusSummary[5], statusSummary[3], statusSummary[1]}
		== $past(sums)) else $error("summary bits wrong");
	chk_level_bits: assert property (
		1 |=> {statusSummary[4], statusSummary[2], statusSummary[0]} == {$past(lvl), 1'b0})
		else $error("level bits wrong");
	chk_master_sum: assert property (
		$stable(summaryEnable) |-> statusSummary[6] == |(statusSummary & summaryEnable & 8'hbf))
		else $error("master bit wrong");
	chk_option_write: assert property (
		take && cmdCode == 4'h2 |=> onClearOption == $past(cmdArg[0]))
		else $error("option write wrong");
	chk_poweron_clear: assert property (
		powerOn && onClearOption |=> summaryEnable == 8'h00 && clearEnables)
		else $error("power-up clear missed");
	chk_poweron_keep: assert property (
		powerOn && !onClearOption && !cmdValid |=> $stable(summaryEnable) && !clearEnables)
		else $error("power-up kept enables wrong");
	chk_clear_status: assert property (
		take && cmdCode == 4'h7 |=> clearEvents && $stable(summaryEnable))
		else $error("clear status wrong");
	chk_trig_start: assert property (
		cmdValid && cmdCode == 4'h8 && armed && busTrigMode |=> startPass ##1 !startPass)
		else $error("trigger start wrong");
	chk_trig_refused: assert property (
		cmdValid && cmdCode == 4'h8 && !(armed && busTrigMode) |=> !startPass)
		else $error("trigger not refused");
	chk_bad_slot: assert property (
		cmdValid && cmdCode == 4'h5 && cmdArg > 8'h05 |=> recallError)
		else $error("bad slot not flagged");
	// main scenarios reached
	cover property (startPass);
	cover property (clearEnables);
	cover property (recallError);
endmodule // status_cfg_monitor

bind status_byte_and_config_store status_cfg_monitor status_cfg_monitor_i (.*);
